// ===== verilog/ssat_params.svh
// register map, field positions and reset values of the serial block
`ifndef SSAT_PARAMS_SVH
`define SSAT_PARAMS_SVH
`define SSAT_IDX_CTRL   15'h7f34
`define SSAT_IDX_BAUD   15'h7f35
`define SSAT_IDX_BUF    15'h7f36
`define SSAT_IDX_GAP_FIELD  15'h7f37
`define SSAT_CTRL_WAKE  7
`define SSAT_CTRL_REC   6
`define SSAT_CTRL_RUN   5
`define SSAT_CTRL_AUTO  4
`define SSAT_CTRL_MSB   3
`define SSAT_CTRL_OVR   2
`define SSAT_CTRL_FLG   1
`define SSAT_CTRL_IE    0
`define SSAT_GAP_FIELD_LEN  6:4
`define SSAT_GAP_FIELD_XCHG 3
`define SSAT_GAP_FIELD_GAP  2:0
`define SSAT_RST_BYTE   8'h00
`define SSAT_RST_BIT    1'b0
`define SSAT_FULL_BITS  4'h8
`endif

// ===== verilog/ssat_pkg.sv
// types shared by the serial block
package ssat_pkg;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FETCH = 3'b001,
      ST_LOAD  = 3'b011,
      ST_SHIFT = 3'b010,
      ST_STORE = 3'b110,
      ST_GAP   = 3'b111,
      ST_SUSP  = 3'b101,
      ST_DONE  = 3'b100
   } ssat_state_t;
endpackage

// ===== verilog/ssat_shifter.sv
// shift register with registered serial output
`timescale 1ns/1ps
module ssat_shifter #(
   parameter int WORD_W = 8
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic              load,
   input  wire logic [WORD_W-1:0] loadData,
   input  wire logic              msbFirst,
   input  wire logic              sample,
   input  wire logic              drive,
   input  wire logic              dataIn,
   output logic      [WORD_W-1:0] shiftData,
   output logic                   serialOut
);
   logic [WORD_W-1:0] sh_q;
   logic [WORD_W-1:0] sh_d;
   logic              out_q;
   logic              out_d;

   if (WORD_W < 2) begin : g_chk
      $error("ssat_shifter needs at least two bits");
   end

   always_comb begin
      sh_d  = sh_q;
      out_d = out_q;
      if (load) begin
         sh_d = loadData;
      end else if (sample) begin
         sh_d = msbFirst ? {sh_q[WORD_W-2:0], dataIn} : {dataIn, sh_q[WORD_W-1:1]};
      end
      if (drive) begin
         out_d = msbFirst ? sh_q[WORD_W-1] : sh_q[0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_q  <= '0;
         out_q <= 1'b1;
      end else begin
         sh_q  <= sh_d;
         out_q <= out_d;
      end
   end

   assign shiftData = sh_q;
   assign serialOut = out_q;
endmodule

// ===== verilog/ssat_top.sv
// serial interface with single-word and automatic streaming modes, apb registers
`timescale 1ns/1ps
`include "ssat_params.svh"
module ssat_top import ssat_pkg::*; #(
   parameter int ADDR_W = 17
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              sckIn,
   output logic                   sckOut,
   output logic                   sckOe,
   input  wire logic              sdiIn,
   output logic                   sdoOut,
   output logic                   ramReq,
   output logic                   ramWrite,
   output logic      [7:0]        ramWdata,
   input  wire logic [7:0]        ramRdata,
   input  wire logic              ramAck,
   input  wire logic [7:0]        xferCountLow,
   input  wire logic [7:0]        bufAddrLow,
   output logic                   irq,
   output logic                   wakeReq
);
   if (ADDR_W < 17) begin : g_chk
      $error("ssat_top needs at least 17 address bits");
   end

   // control register bits
   logic        wake_q;
   logic        wake_d;
   logic        rec_q;
   logic        rec_d;
   logic        run_q;
   logic        run_d;
   logic        auto_q;
   logic        auto_d;
   logic        msb_q;
   logic        msb_d;
   logic        ovr_q;
   logic        ovr_d;
   logic        flg_q;
   logic        flg_d;
   logic        ie_q;
   logic        ie_d;
   // other registers
   logic [7:0]  baud_q;
   logic [7:0]  baud_d;
   logic [7:0]  buf_q;
   logic [7:0]  buf_d;
   logic [2:0]  len_q;
   logic [2:0]  len_d;
   logic        xchg_q;
   logic        xchg_d;
   logic [2:0]  gap_q;
   logic [2:0]  gap_d;
   logic [7:0]  hold_q;
   logic [7:0]  hold_d;
   // sequencing
   ssat_state_t state_q;
   ssat_state_t state_d;
   logic        autoMode_q;
   logic        autoMode_d;
   logic [7:0]  divCnt_q;
   logic [7:0]  divCnt_d;
   logic        sck_q;
   logic        sck_d;
   logic [3:0]  bitCnt_q;
   logic [3:0]  bitCnt_d;
   logic [12:0] rem_q;
   logic [12:0] rem_d;
   logic [7:0]  gapCnt_q;
   logic [7:0]  gapCnt_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic        err_q;
   logic        err_d;
   logic        irq_q;
   logic        irq_d;
   logic        wake_out_q;
   logic        wake_out_d;
   // pin synchronisers
   logic        sckS1_q;
   logic        sckS2_q;
   logic        sckPrev_q;
   logic        sdiS1_q;
   logic        sdiS2_q;

   logic [14:0] addrIdx;
   logic        hitCtrl;
   logic        hitBaud;
   logic        hitBuf;
   logic        hitIntvl;
   logic        wr;
   logic        extClk;
   logic        tick;
   logic        extRise;
   logic        extFall;
   logic        riseE;
   logic        fallE;
   logic        shiftRise;
   logic        byteEnd;
   logic [3:0]  nBits;
   logic [3:0]  byteBits;
   logic        txNeed;
   logic        rxToRam;
   logic [11:0] xCount;
   logic [7:0]  gapHalves;
   logic        shLoad;
   logic [7:0]  shData;
   logic [7:0]  ctrlRd;
   logic        storeDone;

   assign addrIdx  = paddr[16:2];
   assign hitCtrl  = addrIdx == `SSAT_IDX_CTRL;
   assign hitBaud  = addrIdx == `SSAT_IDX_BAUD;
   assign hitBuf   = addrIdx == `SSAT_IDX_BUF;
   assign hitIntvl = addrIdx == `SSAT_IDX_GAP_FIELD;
   assign wr       = psel & penable & pwrite & ~err_q;

   assign extClk    = baud_q == `SSAT_RST_BYTE;
   assign tick      = divCnt_q == baud_q;
   assign extRise   = sckS2_q & ~sckPrev_q;
   assign extFall   = ~sckS2_q & sckPrev_q;
   assign riseE     = extClk ? extRise : (tick & ~sck_q);
   assign fallE     = extClk ? extFall : (tick & sck_q);
   assign shiftRise = riseE & (state_q == ST_SHIFT);
   assign nBits     = (len_q == 3'b000) ? `SSAT_FULL_BITS : {1'b0, len_q};
   assign byteBits  = (!autoMode_q || rem_q == 13'h0000) ? nBits : `SSAT_FULL_BITS;
   assign byteEnd   = shiftRise & ((bitCnt_q + 4'h1) == byteBits);
   // mode decode: transmit uses ram unless receive-only, combined adds exchange
   assign txNeed    = ~rec_q | xchg_q;
   assign rxToRam   = autoMode_q & rec_q;
   assign xCount    = {bufAddrLow[3:0], xferCountLow};
   assign gapHalves = (gap_q == 3'b000) ? 8'h00 : 8'(9'h001 << gap_q);
   assign shLoad    = state_q == ST_LOAD;
   assign storeDone = ~rxToRam | ramAck;
   assign ctrlRd    = {wake_q, rec_q, run_q, auto_q, msb_q, ovr_q, flg_q, ie_q};

   ssat_shifter #(
      .WORD_W (8)
   ) u_shift (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .load      (shLoad),
      .loadData  (buf_q),
      .msbFirst  (msb_q),
      .sample    (shiftRise),
      .drive     (fallE & (state_q == ST_SHIFT)),
      .dataIn    (sdiS2_q),
      .shiftData (shData),
      .serialOut (sdoOut)
   );

   // ram port follows the sequencer; combined mode writes back through the holding buffer
   always_comb begin
      ramReq   = 1'b0;
      ramWrite = 1'b0;
      ramWdata = xchg_q ? hold_q : shData;
      if (state_q == ST_FETCH) begin
         ramReq = 1'b1;
      end else if (state_q == ST_STORE && rxToRam && (!xchg_q || hold_q == shData)) begin
         ramReq   = 1'b1;
         ramWrite = 1'b1;
      end
   end

   always_comb begin
      wake_d     = wake_q;
      rec_d      = rec_q;
      run_d      = run_q;
      auto_d     = auto_q;
      msb_d      = msb_q;
      ovr_d      = ovr_q;
      flg_d      = flg_q;
      ie_d       = ie_q;
      baud_d     = baud_q;
      buf_d      = buf_q;
      len_d      = len_q;
      xchg_d     = xchg_q;
      gap_d      = gap_q;
      hold_d     = hold_q;
      state_d    = state_q;
      autoMode_d = autoMode_q;
      bitCnt_d   = bitCnt_q;
      rem_d      = rem_q;
      gapCnt_d   = gapCnt_q;
      // software writes come first so hardware sets below win
      if (wr && hitCtrl) begin
         wake_d = pwdata[`SSAT_CTRL_WAKE];
         rec_d  = pwdata[`SSAT_CTRL_REC];
         run_d  = pwdata[`SSAT_CTRL_RUN];
         auto_d = pwdata[`SSAT_CTRL_AUTO] & ~pwdata[`SSAT_CTRL_WAKE];
         msb_d  = pwdata[`SSAT_CTRL_MSB];
         ovr_d  = pwdata[`SSAT_CTRL_OVR];
         flg_d  = pwdata[`SSAT_CTRL_FLG];
         ie_d   = pwdata[`SSAT_CTRL_IE];
      end
      if (wr && hitBaud) begin
         baud_d = pwdata[7:0];
      end
      if (wr && hitBuf) begin
         buf_d = pwdata[7:0];
      end
      if (wr && hitIntvl) begin
         len_d  = pwdata[`SSAT_GAP_FIELD_LEN];                             // top bit dropped
         xchg_d = pwdata[`SSAT_GAP_FIELD_XCHG];
         gap_d  = pwdata[`SSAT_GAP_FIELD_GAP];
      end
      unique case (state_q)
         ST_IDLE: begin
            if (run_q) begin
               autoMode_d = auto_q;
               rem_d      = 13'({1'b0, xCount} + 13'h0001);
               state_d    = (auto_q && txNeed) ? ST_FETCH : ST_LOAD;
            end
         end
         ST_FETCH: begin
            if (ramAck) begin
               buf_d   = ramRdata;
               state_d = ST_LOAD;
            end
         end
         ST_LOAD: begin
            bitCnt_d = 4'h0;
            state_d  = ST_SHIFT;
         end
         ST_SHIFT: begin
            if (shiftRise) begin
               bitCnt_d = bitCnt_q + 4'h1;
            end
            if (byteEnd) begin
               state_d = ST_STORE;
            end
         end
         ST_STORE: begin
            if (rec_q && !xchg_q) begin
               buf_d = shData;
            end
            if (xchg_q) begin
               hold_d = shData;
            end
            if (storeDone) begin
               gapCnt_d = extClk ? 8'h00 : gapHalves;
               if (!autoMode_q || rem_q == 13'h0000) begin
                  state_d = ST_DONE;
               end else begin
                  rem_d   = rem_q - 13'h0001;
                  state_d = auto_q ? ST_GAP : ST_SUSP;
               end
            end
         end
         ST_GAP: begin
            if (gapCnt_q == 8'h00) begin
               state_d = txNeed ? ST_FETCH : ST_LOAD;
            end else if (tick) begin
               gapCnt_d = gapCnt_q - 8'h01;
            end
         end
         ST_SUSP: begin
            if (auto_q) begin
               state_d = ST_GAP;
            end
         end
         ST_DONE: begin
            flg_d   = 1'b1;
            run_d   = 1'b0;
            state_d = ST_IDLE;
         end
      endcase
      // software clearing run stops the transfer at once
      if (!run_q && state_q != ST_IDLE) begin
         state_d = ST_IDLE;
      end
      if (extClk && extFall && state_q != ST_SHIFT) begin
         ovr_d = 1'b1;
      end
   end

   // internal clock divider and serial clock level
   always_comb begin
      divCnt_d = 8'h00;
      sck_d    = 1'b1;
      if (!extClk && (state_q == ST_SHIFT || state_q == ST_GAP)) begin
         divCnt_d = tick ? 8'h00 : divCnt_q + 8'h01;
         sck_d    = sck_q;
         if (state_q == ST_SHIFT && tick) begin
            sck_d = ~sck_q;
         end
      end
   end

   // bus read data, error, interrupt and wake outputs
   always_comb begin
      prdata_d = prdata_q;
      err_d    = err_q;
      if (psel && !penable) begin
         err_d    = ~(hitCtrl | hitBaud | hitBuf | hitIntvl);
         prdata_d = 32'h0000_0000;
         if (hitCtrl) begin
            prdata_d[7:0] = ctrlRd;
         end else if (hitBaud) begin
            prdata_d[7:0] = baud_q;
         end else if (hitBuf) begin
            prdata_d[7:0] = buf_q;
         end else if (hitIntvl) begin
            prdata_d[7:0] = {1'b0, len_q, xchg_q, gap_q};
         end
      end
      irq_d      = ie_q & (flg_q | ovr_q);
      wake_out_d = wake_q & ~auto_q & extClk & (flg_q | ovr_q);
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_q     <= `SSAT_RST_BIT;
         rec_q      <= `SSAT_RST_BIT;
         run_q      <= `SSAT_RST_BIT;
         auto_q     <= `SSAT_RST_BIT;
         msb_q      <= `SSAT_RST_BIT;
         ovr_q      <= `SSAT_RST_BIT;
         flg_q      <= `SSAT_RST_BIT;
         ie_q       <= `SSAT_RST_BIT;
         baud_q     <= `SSAT_RST_BYTE;
         buf_q      <= `SSAT_RST_BYTE;
         len_q      <= 3'b000;
         xchg_q     <= `SSAT_RST_BIT;
         gap_q      <= 3'b000;
         hold_q     <= `SSAT_RST_BYTE;
         state_q    <= ST_IDLE;
         autoMode_q <= 1'b0;
         bitCnt_q   <= 4'h0;
         rem_q      <= 13'h0000;
         gapCnt_q   <= 8'h00;
         divCnt_q   <= 8'h00;
         sck_q      <= 1'b1;
         prdata_q   <= 32'h0000_0000;
         err_q      <= 1'b0;
         irq_q      <= 1'b0;
         wake_out_q <= 1'b0;
         sckS1_q    <= 1'b1;
         sckS2_q    <= 1'b1;
         sckPrev_q  <= 1'b1;
         sdiS1_q    <= 1'b0;
         sdiS2_q    <= 1'b0;
      end else begin
         wake_q     <= wake_d;
         rec_q      <= rec_d;
         run_q      <= run_d;
         auto_q     <= auto_d;
         msb_q      <= msb_d;
         ovr_q      <= ovr_d;
         flg_q      <= flg_d;
         ie_q       <= ie_d;
         baud_q     <= baud_d;
         buf_q      <= buf_d;
         len_q      <= len_d;
         xchg_q     <= xchg_d;
         gap_q      <= gap_d;
         hold_q     <= hold_d;
         state_q    <= state_d;
         autoMode_q <= autoMode_d;
         bitCnt_q   <= bitCnt_d;
         rem_q      <= rem_d;
         gapCnt_q   <= gapCnt_d;
         divCnt_q   <= divCnt_d;
         sck_q      <= sck_d;
         prdata_q   <= prdata_d;
         err_q      <= err_d;
         irq_q      <= irq_d;
         wake_out_q <= wake_out_d;
         sckS1_q    <= sckIn;
         sckS2_q    <= sckS1_q;
         sckPrev_q  <= sckS2_q;
         sdiS1_q    <= sdiIn;
         sdiS2_q    <= sdiS1_q;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = psel & penable;
   assign pslverr = psel & penable & err_q;
   assign sckOut  = sck_q;
   assign sckOe   = ~extClk;
   assign irq     = irq_q;
   assign wakeReq = wake_out_q;
endmodule

// ===== verif/ssat_checker.sv
// assertion checker for the serial block ports
`timescale 1ns/1ps
`include "ssat_params.svh"
module ssat_checker #(
   parameter int ADDR_W = 17
) (
   input wire logic              core_clk,
   input wire logic              rst_b,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              sckOut,
   input wire logic              sckOe,
   input wire logic              sdoOut,
   input wire logic              ramReq,
   input wire logic              ramWrite,
   input wire logic              ramAck,
   input wire logic              irq,
   input wire logic              wakeReq
);
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] baud_q;
   logic [7:0] baud_d;
   logic [7:0] half_q;
   logic [7:0] half_d;
   logic       xchg_q;
   logic       xchg_d;
   logic       sckPrev_q;
   logic       wrEn;
   assign wrEn = psel && penable && pwrite;
   // shadow of software settings, phase length counter of the serial clock
   always_comb begin
      ctrl_d = ctrl_q;
      baud_d = baud_q;
      xchg_d = xchg_q;
      if (wrEn && paddr[16:2] == `SSAT_IDX_CTRL) ctrl_d = pwdata[7:0] & {3'h7, ~pwdata[7], 4'hf};
      if (wrEn && paddr[16:2] == `SSAT_IDX_BAUD) baud_d = pwdata[7:0];
      if (wrEn && paddr[16:2] == `SSAT_IDX_GAP_FIELD) xchg_d = pwdata[3];
      half_d = (sckOut != sckPrev_q) ? 8'h00 : half_q + {7'h00, half_q != 8'hff};
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 8'h00;
         baud_q <= 8'h00;
         xchg_q <= 1'b0;
         half_q <= 8'h00;
         sckPrev_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         baud_q <= baud_d;
         xchg_q <= xchg_d;
         half_q <= half_d;
         sckPrev_q <= sckOut;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence ramWait;
      ramReq && !ramAck;
   endsequence
   sequence clkRise;
      sckOe && sckOut && !sckPrev_q;
   endsequence
   chk_half_period: assert property (clkRise |-> half_q == baud_q)
      else $error("serial clock low phase length wrong");
   chk_clk_enable: assert property ($stable(baud_q) |-> sckOe == (baud_q != 8'h00))
      else $error("clock pin enable disagrees with divisor");
   chk_data_stable: assert property (sckOe && $rose(sckOut) |-> $stable(sdoOut))
      else $error("data out moved on rising clock");
   chk_irq_gated: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) |-> !irq)
      else $error("interrupt without enable");
   chk_ram_hold: assert property (ramWait |=> ramReq && $stable(ramWrite))
      else $error("ram request dropped before acknowledge");
   chk_rx_no_fetch: assert property (
      ctrl_q[4] && ctrl_q[6] && !xchg_q |-> !(ramReq && !ramWrite))
      else $error("ram read in automatic receive");
   chk_tx_no_store: assert property (ctrl_q[4] && !ctrl_q[6] |-> !(ramReq && ramWrite))
      else $error("ram write in automatic transmit");
   chk_wake_ext: assert property (wakeReq && $stable(sckOe) |-> !sckOe)
      else $error("wake request with internal clock");
endmodule
bind ssat_top ssat_checker #(.ADDR_W(ADDR_W)) i_ssat_checker (
   .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut),
   .ramReq(ramReq), .ramWrite(ramWrite), .ramAck(ramAck), .irq(irq), .wakeReq(wakeReq));

// ===== verif/ssat_peer.sv
// serial peer model: shifts data both ways, makes the external clock on request
`timescale 1ns/1ps
module ssat_peer (
   input wire logic core_clk,
   input wire logic sckOut,
   input wire logic sckOe,
   input wire logic sdoOut,
   output logic     sckIn,
   output logic     sdiIn
);
   logic [31:0] toSend = 32'h00000000;
   logic [31:0] seen = 32'h00000000;
   int          nSeen = 0;
   int          idle = 0;
   logic        sckPrev = 1'b1;
   wire logic   sck = sckOe ? sckOut : sckIn;
   initial sckIn = 1'b1;
   initial sdiIn = 1'b1;
   task automatic start(input logic [31:0] v);
      toSend = v;
      seen = 32'h00000000;
      nSeen = 0;
   endtask
   // clock stands high outside frames
   task automatic burst(input int n);
      repeat (4) @(posedge core_clk);
      #7;
      repeat (n) begin
         sckIn = 1'b0;
         #160;
         sckIn = 1'b1;
         #160;
      end
   endtask
   always @(posedge core_clk) begin
      sckPrev <= sck;
      if (sckPrev && !sck) begin
         sdiIn <= toSend[31];
         toSend <= {toSend[30:0], 1'b0};
         idle <= 0;
      end else if (!sckPrev && sck) begin
         seen <= {seen[30:0], sdoOut};
         nSeen <= nSeen + 1;
         idle <= 0;
      end else if (idle >= 16) begin
         sdiIn <= ~sdiIn;
      end else begin
         idle <= idle + 1;
      end
   end
endmodule

// ===== verif/tb.sv
// self-checking bench for the serial block
`timescale 1ns/1ps
`include "ssat_params.svh"
module tb;
   logic        core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [16:0] paddr = 17'h00000;
   logic [31:0] pwdata = 32'h00000000, prdata, rnd, st = 32'd98031;
   logic        pready, pslverr, sckIn, sckOut, sckOe, sdiIn, sdoOut, ramReq, ramWrite;
   logic        ramAck = 1'b0, irq, wakeReq;
   logic [7:0]  ramWdata, ramRdata = 8'h00, bufAddrLow = 8'h00, xferCountLow = 8'h00;
   logic [7:0]  ram [4];
   int          numErrors = 0, nCompared = 0, nRd = 0, nWr = 0;
   always #20 core_clk = ~core_clk;
   ssat_top #(.ADDR_W(17)) i_ssat_top (
      .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .sdiIn(sdiIn), .sdoOut(sdoOut),
      .ramReq(ramReq), .ramWrite(ramWrite), .ramWdata(ramWdata), .ramRdata(ramRdata),
      .ramAck(ramAck), .xferCountLow(xferCountLow), .bufAddrLow(bufAddrLow), .irq(irq),
      .wakeReq(wakeReq));
   ssat_peer i_ssat_peer (.core_clk(core_clk), .sckOut(sckOut), .sckOe(sckOe),
      .sdoOut(sdoOut), .sckIn(sckIn), .sdiIn(sdiIn));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] expTx(input logic [7:0] d, input int n, input logic m);
      logic [31:0] r;
      r = 32'h00000000;
      for (int i = 0; i < n; i++) r[n-1-i] = m ? d[7-i] : d[i];
      return r;
   endfunction
   // transfer controller ram: random stalls, one-cycle acknowledge
   always @(posedge core_clk) begin
      st <= lfsr(st);
      ramAck <= 1'b0;
      if (ramReq && !ramAck && st[0]) begin
         ramAck <= 1'b1;
         if (ramWrite) begin
            ram[nWr] <= ramWdata;
            nWr <= nWr + 1;
         end else begin
            ramRdata <= ram[nRd];
            nRd <= nRd + 1;
         end
      end
   end
   task automatic completeRun;
      $display("compared %0d, errors %0d", nCompared, numErrors);
      if (numErrors == 0 && nCompared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      nCompared++;
      if (got !== exp) begin
         numErrors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [14:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         numErrors++;
         completeRun();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [14:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      apb(1'b1, idx, d, r, e);
   endtask
   task automatic rdchk(input string what, input logic [14:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic       e;
      apb(1'b0, idx, 8'h00, r, e);
      check(what, {24'h000000, exp}, {24'h000000, r});
   endtask
   task automatic waitDone(input logic [7:0] exp);
      logic [7:0] c;
      logic       e;
      int         n;
      n = 0;
      do begin
         apb(1'b0, `SSAT_IDX_CTRL, 8'h00, c, e);
         n++;
      end while (c[1] !== 1'b1 && n < 2000);
      check("control at end", {24'h000000, exp}, {24'h000000, c});
      if (n >= 2000) completeRun();
   endtask
   initial begin
      logic [7:0] r;
      logic       e, msb;
      int         len, x;
      rnd = 32'd98031;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      for (int i = 0; i < 4; i++) rdchk("reset value", 15'h7f34 + 15'(i), 8'h00);
      apb(1'b0, 15'h7f38, 8'h00, r, e);
      check("unmapped error", 32'h1, {31'h0, e});
      wr(`SSAT_IDX_GAP_FIELD, 8'h7a);
      rdchk("gap and length", `SSAT_IDX_GAP_FIELD, 8'h7a);
      for (int code = 0; code < 8; code++) begin
         rnd = lfsr(rnd);
         len = (code == 0) ? 8 : code;
         msb = (code == 0) & rnd[10];
         wr(`SSAT_IDX_BAUD, 8'h03 + {6'h00, rnd[9:8]});
         check("irq cleared", 32'h0, {31'h0, irq});
         wr(`SSAT_IDX_BUF, rnd[7:0]);
         wr(`SSAT_IDX_GAP_FIELD, {1'b0, code[2:0], 4'h0});
         i_ssat_peer.start(32'h00000000);
         wr(`SSAT_IDX_CTRL, {4'h2, msb, 3'b001});
         waitDone({4'h0, msb, 3'b011});
         check("irq at end", 32'h1, {31'h0, irq});
         check("bit count", len, i_ssat_peer.nSeen);
         check("tx bits", expTx(rnd[7:0], len, msb),
               i_ssat_peer.seen & ((32'h1 << len) - 32'h1));
         wr(`SSAT_IDX_CTRL, 8'h00);
      end
      for (int ext = 0; ext < 2; ext++) begin
         rnd = lfsr(rnd);
         wr(`SSAT_IDX_BAUD, (ext == 1) ? 8'h00 : 8'h04);
         wr(`SSAT_IDX_GAP_FIELD, 8'h00);
         i_ssat_peer.start({rnd[7:0], 24'h000000});
         wr(`SSAT_IDX_CTRL, 8'h68);
         if (ext == 1) i_ssat_peer.burst(8);
         waitDone(8'h4a);
         rdchk("rx buffer", `SSAT_IDX_BUF, rnd[7:0]);
         wr(`SSAT_IDX_CTRL, 8'h00);
      end
      wr(`SSAT_IDX_CTRL, 8'h91);
      i_ssat_peer.burst(1);
      repeat (4) @(posedge core_clk);
      rdchk("wake and overrun", `SSAT_IDX_CTRL, 8'h85);
      check("irq on overrun", 32'h1, {31'h0, irq});
      check("wake request", 32'h1, {31'h0, wakeReq});
      wr(`SSAT_IDX_CTRL, 8'h00);
      for (int m = 0; m < 3; m++) begin
         rnd = lfsr(rnd);
         len = 1 + int'(rnd[2:0]) % 7;
         x = int'(rnd[26]);
         ram[0] = rnd[15:8];
         ram[1] = rnd[23:16];
         ram[2] = ~rnd[15:8];
         nRd = 0;
         nWr = 0;
         bufAddrLow <= {rnd[7:4], 4'h0};
         xferCountLow <= 8'(x);
         wr(`SSAT_IDX_BAUD, 8'h03);
         wr(`SSAT_IDX_GAP_FIELD, {1'b0, 3'(len), m == 2, 1'b0, rnd[25:24]});
         i_ssat_peer.start(rnd);
         wr(`SSAT_IDX_CTRL, {1'b0, m != 0, 6'h38});
         if (m == 2) begin
            wr(`SSAT_IDX_CTRL, 8'h68);
            repeat (200) @(posedge core_clk);
            rdchk("suspended control", `SSAT_IDX_CTRL, 8'h68);
            check("suspended bits", 32'd8, i_ssat_peer.nSeen);
            wr(`SSAT_IDX_CTRL, 8'h78);
         end
         waitDone({1'b0, m != 0, 6'h1a});
         check("bits moved", 8 * (x + 1) + len, i_ssat_peer.nSeen);
         check("ram reads", (m == 1) ? 0 : x + 2, nRd);
         check("ram writes", (m == 0) ? 0 : x + 2, nWr);
         if (m != 1) check("first tx byte", rnd[15:8],
                           (i_ssat_peer.seen >> (8 * x + len)) & 32'hff);
         if (m != 0) check("ram written back", rnd[31:24], ram[0]);
         wr(`SSAT_IDX_CTRL, 8'h00);
      end
      completeRun();
   end
endmodule
